// *** bench/csi_clock_select_rx_buffers_bench.sv ***
// Purpose: register-level test of clock select and receive buffers
// Assumes: ack one cycle after request, active flag at ctrl bit 0
// Notes: the partner model feeds the data line
module csi_clock_select_rx_buffers_bench;
	import csi_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, cyc, stb, we, tick, sck_in, clr, wide;
	logic ack, sck_out, sck_oe, si, so;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [1:0] tcnt;
	logic [31:0] wdat, rdat, q;
	int failures = 0;
	int n_checks = 0;
	int p;
	csi_clock_select_rx_buffers #(.FIFO_DEPTH(16)) dut (.CORE_CLK(clk), .RESET(rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BAUD_TICK(tick),
		.SCK_IN(sck_in), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SI_IN(si), .SO_OUT(so));
	csi_link_partner lp (.clk(clk), .clr(clr), .sck(sck_oe ? sck_out : sck_in),
		.wide(wide), .si(si));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		tcnt <= (rst || tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
		tick <= !rst && (tcnt == 2'h2);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) failures++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 4'hf, 32'h0);
		chk(q, exp);
	endtask : rd
	task automatic cfg(input logic [7:0] ctrl, input logic [2:0] cks);
		wb(1'b1, CSI_CTRL_ADDR, 4'hf, 32'h0);
		wb(1'b1, CSI_CLKSEL_ADDR, 4'hf, {29'h0, cks});
		wb(1'b1, CSI_CTRL_ADDR, 4'hf, {24'h0, ctrl});
		@(posedge clk);
		clr <= 1'b1;
		wide <= ctrl[CSI_WL_BIT];
		@(posedge clk);
		clr <= 1'b0;
	endtask : cfg
	task automatic idle;
		for (int n = 0; n < 1000; n++) begin
			wb(1'b0, CSI_CTRL_ADDR, 4'hf, 32'h0);
			if (q[CSI_ACTIVE_BIT] === 1'b0) break;
		end
		chk({31'h0, q[CSI_ACTIVE_BIT]}, 32'h0);
	endtask : idle
	task automatic per(output int r);
		for (int n = 0; n < 400 && sck_out !== 1'b0; n++) @(posedge clk);
		for (int n = 0; n < 400 && sck_out !== 1'b1; n++) @(posedge clk);
		for (int n = 0; n < 400 && sck_out !== 1'b0; n++) @(posedge clk);
		for (r = 0; r < 400 && sck_out !== 1'b1; r++) @(posedge clk);
		for (; r < 400 && sck_out !== 1'b0; r++) @(posedge clk);
	endtask : per
	task automatic print_verdict;
		if (failures == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		{cyc, stb, we, sck_in, clr, wide} = 6'h0c;
		{adr, sel, wdat} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		clr <= 1'b0;
		rd(CSI_CTRL_ADDR, {24'h0, CSI_CTRL_RESET});
		rd(CSI_CLKSEL_ADDR, {29'h0, CSI_CLKSEL_RESET});
		rd(CSI_MIRROR_ADDR, 32'h0);
		rd(8'h20, 32'h0);
		chk({30'h0, sck_out, so}, 32'h2);
		for (int k = 0; k < 8; k++) begin
			cfg(8'h80, 3'(k));
			rd(CSI_LOW_ADDR, 32'h0);
			if (k < 7) begin
				chk({31'h0, sck_oe}, 32'h1);
				per(p);
				chk(32'(p), (k < 6) ? 32'h2 << (6 - k) : 32'h6);
			end else begin
				chk({31'h0, sck_oe}, 32'h0);
				repeat (8) begin
					repeat (8) @(posedge clk);
					sck_in <= 1'b0;
					repeat (8) @(posedge clk);
					sck_in <= 1'b1;
				end
			end
			idle();
			rd(CSI_LOW_ADDR, 32'he1);
		end
		cfg(8'ha0, 3'h5);
		rd(CSI_WORD_ADDR, 32'h0);
		rd(CSI_CTRL_ADDR, 32'ha1);
		idle();
		rd(CSI_MIRROR_ADDR, 32'hb4e1);
		rd(CSI_CTRL_ADDR, 32'ha0);
		wb(1'b0, CSI_WORD_ADDR, 4'h1, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, CSI_WORD_ADDR, 4'hf, 32'h1234);
		rd(CSI_CTRL_ADDR, 32'ha0);
		rd(CSI_WORD_ADDR, 32'hb4e1);
		rd(CSI_CTRL_ADDR, 32'ha1);
		idle();
		wb(1'b1, CSI_CLKSEL_ADDR, 4'hf, 32'h0);
		rd(CSI_CLKSEL_ADDR, 32'h5);
		rd(CSI_MIRROR_ADDR, 32'hc5f2);
		wb(1'b1, CSI_CTRL_ADDR, 4'hf, 32'h0);
		rd(CSI_MIRROR_ADDR, 32'h0);
		cfg(8'hc0, 3'h5);
		rd(CSI_LOW_ADDR, 32'h0);
		rd(CSI_CTRL_ADDR, 32'hc0);
		cfg(8'h84, 3'h5);
		rd(CSI_LOW_ADDR, 32'h0);
		repeat (800) @(posedge clk);
		rd(CSI_CTRL_ADDR, 32'h84);
		for (int f = 0; f < 17; f++) rd(CSI_LOW_ADDR, {24'h0, 8'(8'he1 + 8'h11 * f)});
		print_verdict();
	end
endmodule : csi_clock_select_rx_buffers_bench

// *** bench/csi_link_partner.sv ***
// Purpose: serial peripheral model driving the receive data line
// Assumes: data moves three clocks after each rising serial clock
// Notes: frame f carries 16'hb4e1 plus f times 16'h1111, msb first
module csi_link_partner (
	input wire logic clk,
	input wire logic clr,
	input wire logic sck,
	input wire logic wide,
	output logic si
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] sck_d;
	int cnt;
	int nb;
	logic [15:0] word;
	assign nb = wide ? 16 : 8;
	assign word = 16'hb4e1 + 16'h1111 * 16'(cnt / nb);
	assign si = word[nb - 1 - cnt % nb];
	always_ff @(posedge clk) begin
		if (clr) begin
			cnt <= 0;
			sck_d <= 3'h7;
		end else begin
			sck_d <= {sck_d[1:0], sck};
			if (sck_d[1] && !sck_d[2]) cnt <= cnt + 1;
		end
	end
endmodule : csi_link_partner

// *** include/csi_pkg.sv ***
// Purpose: constants and types of the serial clock select and receive buffer block
// Assumes: 32-bit classic Wishbone register bus, one aligned word per register
package csi_pkg;
	localparam logic [7:0] CSI_CTRL_ADDR = 8'h00;
	localparam logic [7:0] CSI_CLKSEL_ADDR = 8'h04;
	localparam logic [7:0] CSI_WORD_ADDR = 8'h08;
	localparam logic [7:0] CSI_LOW_ADDR = 8'h0c;
	localparam logic [7:0] CSI_MIRROR_ADDR = 8'h10;
	localparam int CSI_EN_BIT = 7;
	localparam int CSI_MODE_BIT = 6;
	localparam int CSI_WL_BIT = 5;
	localparam int CSI_REPEAT_BIT = 2;
	localparam int CSI_ACTIVE_BIT = 0;
	localparam logic [7:0] CSI_CTRL_RESET = 8'h00;
	localparam logic [2:0] CSI_CLKSEL_RESET = 3'h0;
	localparam logic [15:0] CSI_BUF_RESET = 16'h0000;
	localparam logic [2:0] CSI_CKS_BAUD = 3'h6;
	localparam logic [2:0] CSI_CKS_SLAVE = 3'h7;
	localparam logic [6:0] CSI_DIV_TOP = 7'h40;
	localparam logic [4:0] CSI_BITS_8 = 5'h08;
	localparam logic [4:0] CSI_BITS_16 = 5'h10;
	localparam int CSI_FIFO_DEPTH = 16;
	localparam int CSI_WORD_W = 16;
	typedef enum logic {ST_IDLE, ST_RUN} csi_state_t;
endpackage : csi_pkg

// *** include/csi_stream_if.sv ***
// Purpose: valid/ready word stream between the receive engine, FIFO and buffer
// Assumes: one clock shared by both ends
// Notes: fill side pushes, drain side pops
interface csi_stream_if #(parameter int W = 16);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, output in_ready, input in_data,
		output out_valid, input out_ready, output out_data);
	modport user (output in_valid, input in_ready, output in_data,
		input out_valid, output out_ready, input out_data);
endinterface : csi_stream_if

// *** src/csi_clock_select_rx_buffers.sv ***
// Purpose: serial clock selection, receive engine and receive buffer read path
// Assumes: pins synchronous to CORE_CLK; classic Wishbone slave, ack one cycle after request
// Notes: unit enable low holds the channel in clear
module csi_clock_select_rx_buffers
	import csi_pkg::*;
#(
	parameter int FIFO_DEPTH = CSI_FIFO_DEPTH
) (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic BAUD_TICK,
	input wire logic SCK_IN,
	output logic SCK_OUT,
	output logic SCK_OE,
	input wire logic SI_IN,
	output logic SO_OUT
);
	logic ack_r;
	logic [31:0] dat_r;
	logic en_r;
	logic mode_r;
	logic wl_r;
	logic repeat_r;
	logic [2:0] cks_r;
	logic active_r;
	logic pend_r;
	csi_state_t state_r;
	logic [4:0] bit_r;
	logic [15:0] shift_r;
	logic sck_r;
	logic ext_q_r;
	logic ext_p_r;
	logic [6:0] div_r;
	logic push_r;
	logic [15:0] push_data_r;
	logic [15:0] rxbuf_r;
	logic full_r;

	csi_stream_if #(.W(CSI_WORD_W)) strm ();

	// bus decode
	wire req = WB_CYC_I && WB_STB_I && !ack_r;
	// writes land at the edge where the master samples ack high
	wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_r;
	wire rd = req && !WB_WE_I;
	wire hit_ctrl = (WB_ADR_I == CSI_CTRL_ADDR);
	wire hit_cks = (WB_ADR_I == CSI_CLKSEL_ADDR);
	wire word_sel_ok = (WB_SEL_I[1:0] == 2'h3);
	wire rd_word = rd && (WB_ADR_I == CSI_WORD_ADDR) && word_sel_ok;
	wire rd_low = rd && (WB_ADR_I == CSI_LOW_ADDR) && WB_SEL_I[0];
	wire rd_mirror = rd && (WB_ADR_I == CSI_MIRROR_ADDR) && word_sel_ok;
	wire clr = RESET || !en_r;
	wire rd_start = (rd_word || rd_low) && en_r && !mode_r;
	wire slave = (cks_r == CSI_CKS_SLAVE);
	wire [4:0] last_bit = wl_r ? CSI_BITS_16 : CSI_BITS_8;
	wire [7:0] ctrl_val = {en_r, mode_r, wl_r, 2'h0, repeat_r, 1'h0, active_r};

	// clock selection
	wire [6:0] div_mask = (CSI_DIV_TOP >> cks_r) - 7'h01;
	wire div_tick = &(div_r | ~div_mask);
	wire master_tick = (cks_r == CSI_CKS_BAUD) ? BAUD_TICK : div_tick;
	wire ext_rise = ext_q_r && !ext_p_r;
	wire run = (state_r == ST_RUN);
	wire samp = run && (slave ? ext_rise : (master_tick && !sck_r));
	wire fall = run && !slave && master_tick && sck_r;
	wire done = samp && ((bit_r + 5'h01) == last_bit);
	wire start = (state_r == ST_IDLE) && pend_r && strm.in_ready;

	logic [31:0] rd_mux;
	assign rd_mux = hit_ctrl ? {24'h0, ctrl_val} :
		hit_cks ? {29'h0, cks_r} :
		rd_word ? {16'h0, rxbuf_r} :
		rd_low ? {24'h0, rxbuf_r[7:0]} :
		rd_mirror ? {16'h0, rxbuf_r} : 32'h0;

	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
	assign SCK_OUT = sck_r;
	assign SCK_OE = en_r && !slave;
	assign SO_OUT = 1'b0;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0;
		end else begin
			ack_r <= req;
			if (rd) dat_r <= rd_mux;
		end
	end

	// control and clock select; clock select only changes while disabled
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			en_r <= CSI_CTRL_RESET[CSI_EN_BIT];
			mode_r <= CSI_CTRL_RESET[CSI_MODE_BIT];
			wl_r <= CSI_CTRL_RESET[CSI_WL_BIT];
			repeat_r <= CSI_CTRL_RESET[CSI_REPEAT_BIT];
			cks_r <= CSI_CLKSEL_RESET;
		end else if (wr && WB_SEL_I[0]) begin
			if (hit_ctrl) begin
				en_r <= WB_DAT_I[CSI_EN_BIT];
				mode_r <= WB_DAT_I[CSI_MODE_BIT];
				wl_r <= WB_DAT_I[CSI_WL_BIT];
				repeat_r <= WB_DAT_I[CSI_REPEAT_BIT];
			end
			if (hit_cks && !en_r) cks_r <= WB_DAT_I[2:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			div_r <= 7'h0;
			ext_q_r <= 1'b1;
			ext_p_r <= 1'b1;
		end else begin
			div_r <= div_r + 7'h01;
			ext_q_r <= SCK_IN;
			ext_p_r <= ext_q_r;
		end
	end

	// start requests: word and low view buffer reads in receive-only mode, or auto restart in repeat mode
	always_ff @(posedge CORE_CLK) begin
		if (clr) begin
			pend_r <= 1'b0;
		end else if (rd_start || (done && repeat_r)) begin
			pend_r <= 1'b1;
		end else if (start) begin
			pend_r <= 1'b0;
		end
	end

	// receive engine
	always_ff @(posedge CORE_CLK) begin
		if (clr) begin
			state_r <= ST_IDLE;
			active_r <= 1'b0;
			bit_r <= 5'h0;
			shift_r <= CSI_BUF_RESET;
			sck_r <= 1'b1;
			push_r <= 1'b0;
			push_data_r <= CSI_BUF_RESET;
		end else begin
			push_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					sck_r <= 1'b1;
					if (start) begin
						state_r <= ST_RUN;
						active_r <= 1'b1;
						bit_r <= 5'h0;
					end
				end
				ST_RUN: begin
					if (fall) sck_r <= 1'b0;
					if (samp) begin
						sck_r <= 1'b1;
						shift_r <= {shift_r[14:0], SI_IN};
						bit_r <= bit_r + 5'h01;
					end
					if (done) begin
						state_r <= ST_IDLE;
						active_r <= 1'b0;
						push_r <= 1'b1;
						push_data_r <= wl_r ? {shift_r[14:0], SI_IN} :
							{8'h00, shift_r[6:0], SI_IN};
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign strm.in_valid = push_r;
	assign strm.in_data = push_data_r;
	assign strm.out_ready = !full_r;

	csi_rx_fifo #(.W(CSI_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(CORE_CLK),
		.clr(clr),
		.s(strm)
	);

	// receive buffer, loaded from the FIFO once the previous word was read through the word or low view
	always_ff @(posedge CORE_CLK) begin
		if (clr) begin
			rxbuf_r <= CSI_BUF_RESET;
			full_r <= 1'b0;
		end else if (strm.out_valid && !full_r) begin
			rxbuf_r <= strm.out_data;
			full_r <= 1'b1;
		end else if (rd_word || rd_low) begin
			full_r <= 1'b0;
		end
	end

	clk_div_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(en_r && cks_r == 3'h5 && div_tick) |-> ##2 div_tick)
		else $error("divide by 4 half period wrong");
	word_start_a: assert property (@(posedge CORE_CLK) disable iff (clr)
		(rd_word && !mode_r) |=> (pend_r || active_r))
		else $error("word read did not start reception");
	low_start_a: assert property (@(posedge CORE_CLK) disable iff (clr)
		(rd_low && !mode_r) |=> (pend_r || active_r))
		else $error("low view read did not start reception");
	buf_clear_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		$fell(en_r) |=> (rxbuf_r == CSI_BUF_RESET && !active_r))
		else $error("buffer not cleared on disable");
	low_view_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		rd_low |=> (WB_DAT_O == {24'h0, $past(rxbuf_r[7:0])}))
		else $error("low view data mismatch");
	mirror_data_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		rd_mirror |=> (WB_DAT_O == {16'h0, $past(rxbuf_r)} && WB_ACK_O))
		else $error("mirror data mismatch");
	mirror_nostart_a: assert property (@(posedge CORE_CLK) disable iff (clr)
		(rd_mirror && !pend_r && !active_r && !done) |=> !pend_r)
		else $error("mirror read started reception");
	byte_len_a: assert property (@(posedge CORE_CLK) disable iff (clr)
		(done && !wl_r) |=> (push_r && push_data_r[15:8] == 8'h00))
		else $error("8-bit word carries upper byte");
	active_end_a: assert property (@(posedge CORE_CLK) disable iff (clr)
		done |=> (!active_r && push_r))
		else $error("active flag not cleared after last bit");
endmodule : csi_clock_select_rx_buffers

// *** src/csi_rx_fifo.sv ***
// Purpose: flip-flop FIFO for received words
// Assumes: synchronous active-high clear
// Notes: full and empty come from an occupancy count
module csi_rx_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic clr,
	csi_stream_if.fifo s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	wire push = s.in_valid && s.in_ready;
	wire pop = s.out_valid && s.out_ready;
	assign s.in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign s.out_valid = (cnt_r != '0);
	assign s.out_data = mem_r[rd_r];
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_r] <= s.in_data;
		end
	end
	always_ff @(posedge clk) begin
		if (clr) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) wr_r <= wr_r + AW'(1);
			if (pop) rd_r <= rd_r + AW'(1);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	fifo_bound_a: assert property (@(posedge clk) disable iff (clr)
		cnt_r == (AW+1)'(DEPTH) |-> !s.in_ready)
		else $error("fifo accepts while full");
endmodule : csi_rx_fifo
